// ---- ulc_top.sv ----
// ulc_top.sv: serial line status/control with LIN break, inversion, nine-bit
// assumes an AHB-Lite master with single word transfers and one clock
//
// Functional notes
// - lin break flag sets on detection, write-one clears
// - active rx edge sets edge flag, polarity follows invert except in loopback
// - rx invert flips every received level except on the internal loopback path
// - standby idle sets idle flag only if enabled
// - tx break 10/13 bits, one more nine-bit
// - framing detection independent of long break bit
// - break threshold 10 or 11, plus nine-bit
// - lin detect blocks framing and full flags
// - active flag: set at start, cleared at idle
// - ninth received bit shown in control three
// - ninth tx bit moves with data byte
// - single-wire mode: direction bit drives tx enable
// - tx invert flips every transmitted level
// - overrun flag and enable request interrupt
// - noise flag and enable request interrupt
// - framing flag and enable request interrupt
// - parity flag and enable request interrupt
// - low stop sample sets framing with full
// - nine-bit frame is eleven bits long
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
`default_nettype none

module ulc_top
   import ulc_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output var  logic [31:0] hrdata,
   output var  logic        hreadyout,
   output var  logic        hresp,
   input  wire logic        rxPin,
   input  wire logic        txPinIn,
   output var  logic        txPinOut,
   output var  logic        txPinOe,
   output var  logic        errIrq
);

   // ----------------------------------------------------------------
   // state and helpers
   // ----------------------------------------------------------------
   ulc_state_t s;
   ulc_state_t next_s;
   logic       rxSync;
   logic       txSync;
   logic       tick;
   logic       swMode;
   logic       lpMode;
   logic       line;
   logic       edgeEv;
   logic       txRaw;
   logic       nine;
   logic       acc;
   logic [3:0] add9;
   logic [3:0] nb;
   logic [3:0] flen;
   logic [3:0] thr;
   logic [7:0] brkTicks;

   ulc_sync #(.RST(1'b1)) u_rxSync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .d       (rxPin),
      .q       (rxSync)
   );

   ulc_sync #(.RST(1'b1)) u_txSync (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .d       (txPinIn),
      .q       (txSync)
   );

   ulc_baud #(.W(13)) u_baud (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .div     (s.baud),
      .tick    (tick)
   );

   // ----------------------------------------------------------------
   // line selection and frame sizes
   // ----------------------------------------------------------------
   assign swMode = s.ctl[B_LOOPBACK] && s.ctl[B_SINGLEWIRE];
   assign lpMode = s.ctl[B_LOOPBACK] && !s.ctl[B_SINGLEWIRE];
   assign txRaw  = (s.txSt == TX_SHIFT) ? s.txSh[0] : (s.txSt != TX_BRK);
   // inversion applies to start, data, stop, break and idle alike
   assign line   = lpMode ? txRaw : ((swMode ? txSync : rxSync) ^ s.st2[B_RXINVERT]);
   assign edgeEv = s.rxPrev && !line;
   assign acc    = hsel && htrans[1] && hready;
   assign nine   = s.ctl[B_NINEBIT];
   assign add9   = nine ? NINE_ADD : 4'h0;
   assign nb     = nine ? DATA9 : DATA8;
   assign flen   = nine ? FRAME9 : FRAME8;
   assign thr    = (s.st2[B_LINDET] ? BRK_DET_LIN : BRK_DET_STD) + add9;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_s = s;
      next_s.dVal = 1'b0;

      // data phase of a write
      if (s.dVal && s.dWr) begin
         case (s.dAdr)
            OFS_STAT2: begin
               // flags clear on one, the active bit ignores writes
               next_s.st2 = {s.st2[7:6] & ~hwdata[7:6], 1'b0, hwdata[4:1],
                             s.st2[B_RXACTIVE]};
            end
            OFS_CTRL3: begin
               next_s.ct3 = {s.ct3[B_RXNINTH], hwdata[6:0]};
            end
            OFS_CTRL: begin
               next_s.ctl = hwdata[7:0];
            end
            OFS_BAUD: begin
               next_s.baud = hwdata[12:0];
            end
            default: begin
            end
         endcase
      end

      // address phase; reads sample here so side effects stay ordered
      if (acc) begin
         next_s.dVal = 1'b1;
         next_s.dWr  = hwrite;
         next_s.dAdr = haddr[4:0];
         next_s.rdat = 16'h0000;
         if (!hwrite && haddr[31:5] == 27'h000_0000) begin
            case (haddr[4:0])
               OFS_STAT2: begin
                  next_s.rdat[7:0] = s.st2;
               end
               OFS_CTRL3: begin
                  next_s.rdat[7:0] = s.ct3;
               end
               OFS_CTRL: begin
                  next_s.rdat[7:0] = s.ctl;
               end
               OFS_STAT1: begin
                  next_s.rdat[7:0] = s.st1;
                  next_s.armed     = 1'b1;
               end
               OFS_DATA: begin
                  next_s.rdat[7:0] = s.rxd;
                  // status read then data read clears the receive flags
                  if (s.armed) begin
                     next_s.st1   = 8'h00;
                     next_s.armed = 1'b0;
                  end
               end
               OFS_BAUD: begin
                  next_s.rdat[12:0] = s.baud;
               end
               default: begin
               end
            endcase
         end
      end

      // ----------------------------------------------------------------
      // receiver
      // ----------------------------------------------------------------
      next_s.rxPrev = line;
      if (edgeEv) begin
         next_s.st2[B_RXEDGE] = 1'b1;
      end
      if (s.rxSt == RX_IDLE && edgeEv && s.ctl[B_RXENABLE]) begin
         next_s.rxSt  = RX_START;
         next_s.rxSub = 4'h0;
         next_s.rxNz  = 1'b0;
      end else if (tick) begin
         next_s.rxSub = s.rxSub + 4'h1;
         if (s.rxSub == SUB_PRE) begin
            next_s.smp = line;
         end
         if ((s.rxSub == SUB_MID || s.rxSub == SUB_POST) && line != s.smp
             && s.rxSt != RX_IDLE) begin
            next_s.rxNz = 1'b1;
         end
         if (s.rxSub == SUB_MID) begin
            next_s.zRun = line ? 4'h0 : ((s.zRun == RUN_MAX) ? RUN_MAX : s.zRun + 4'h1);
            next_s.oRun = !line ? 4'h0 : ((s.oRun == RUN_MAX) ? RUN_MAX : s.oRun + 4'h1);
            // a low run reaching the threshold is a lin break
            if (!line && s.zRun + 4'h1 == thr && s.st2[B_LINDET]) begin
               next_s.st2[B_LINBRK] = 1'b1;
            end
            unique case (s.rxSt)
               RX_IDLE: begin
                  if (line && s.st2[B_RXACTIVE] && s.oRun + 4'h1 == flen) begin
                     next_s.st2[B_RXACTIVE] = 1'b0;
                     if (!s.ctl[B_STANDBY]) begin
                        next_s.st1[B_IDLEFLAG] = 1'b1;
                     end else begin
                        next_s.ctl[B_STANDBY] = 1'b0;
                        if (s.st2[B_IDLEWAKE]) begin
                           next_s.st1[B_IDLEFLAG] = 1'b1;
                        end
                     end
                  end
               end
               RX_START: begin
                  if (line) begin
                     next_s.rxSt = RX_IDLE;
                  end else begin
                     next_s.st2[B_RXACTIVE] = 1'b1;
                  end
               end
               RX_DATA: begin
                  if (s.rxBit == nb) begin
                     next_s.rxSt = line ? RX_IDLE : RX_HOLD;
                     // lin detect holds back full and framing entirely
                     if (!s.st2[B_LINDET] && !s.ctl[B_STANDBY]) begin
                        if (s.st1[B_RXFULL]) begin
                           next_s.st1[B_OVERRUN] = 1'b1;
                        end else begin
                           next_s.st1[B_RXFULL]  = 1'b1;
                           // long break bit has no say in framing checks
                           next_s.st1[B_FRAMING] = !line;
                           next_s.st1[B_NOISE]   = s.rxNz;
                           next_s.st1[B_PARITY]  = s.ctl[B_PARITYEN]
                              && (nine ? ^s.rxSh : ^s.rxSh[8:1]);
                           next_s.rxd = nine ? s.rxSh[7:0] : s.rxSh[8:1];
                           next_s.ct3[B_RXNINTH] = nine && s.rxSh[8];
                        end
                     end
                  end else begin
                     next_s.rxSh = {line, s.rxSh[8:1]};
                  end
               end
               RX_HOLD: begin
                  if (line) begin
                     next_s.rxSt = RX_IDLE;
                  end
               end
            endcase
         end
         if (s.rxSub == SUB_LAST) begin
            if (s.rxSt == RX_START) begin
               next_s.rxSt  = RX_DATA;
               next_s.rxBit = 4'h0;
            end else if (s.rxSt == RX_DATA) begin
               next_s.rxBit = s.rxBit + 4'h1;
            end
         end
      end

      // ----------------------------------------------------------------
      // transmitter
      // ----------------------------------------------------------------
      if (tick) begin
         next_s.txSub = s.txSub + 4'h1;
         if (s.txSub == SUB_LAST) begin
            case (s.txSt)
               TX_IDLE: begin
                  if (s.ctl[B_TXENABLE] && s.txFull) begin
                     next_s.txSt   = TX_SHIFT;
                     next_s.txSh   = nine ? {1'b1, s.txBuf, 1'b0}
                                          : {2'b11, s.txBuf[7:0], 1'b0};
                     next_s.txLen  = flen;
                     next_s.txBit  = 4'h0;
                     next_s.txFull = 1'b0;
                  end else if (s.ctl[B_TXENABLE] && s.ctl[B_SENDBRK]) begin
                     next_s.txSt  = TX_BRK;
                     next_s.txLen = (s.st2[B_LONGBRK] ? BRK_TX_LONG : BRK_TX_STD)
                                    + add9;
                     next_s.txBit = 4'h0;
                  end
               end
               TX_SHIFT, TX_BRK: begin
                  next_s.txSh  = {1'b1, s.txSh[10:1]};
                  next_s.txBit = s.txBit + 4'h1;
                  if (s.txBit == s.txLen - 4'h1) begin
                     next_s.txSt = TX_IDLE;
                  end
               end
               default: begin
                  next_s.txSt = TX_IDLE;
               end
            endcase
         end
      end
      // after the load so a write in the load cycle is not lost
      if (s.dVal && s.dWr && s.dAdr == OFS_DATA) begin
         next_s.txBuf  = {s.ct3[B_TXNINTH], hwdata[7:0]};
         next_s.txFull = 1'b1;
      end

      // ----------------------------------------------------------------
      // registered outputs
      // ----------------------------------------------------------------
      next_s.rdy   = 1'b1;
      next_s.txPin = txRaw ^ s.ct3[B_TXINVERT];
      next_s.txOe  = swMode ? s.ct3[B_TXDIRECT] : 1'b1;
      next_s.irq   = (s.st1[B_OVERRUN] && s.ct3[B_OVRIE])
                  || (s.st1[B_NOISE] && s.ct3[B_NOISEIE])
                  || (s.st1[B_FRAMING] && s.ct3[B_FRAMEIE])
                  || (s.st1[B_PARITY] && s.ct3[B_PARIE]);
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign hrdata    = {16'h0000, s.rdat};
   assign hreadyout = s.rdy;
   assign hresp     = 1'b0;
   assign txPinOut  = s.txPin;
   assign txPinOe   = s.txOe;
   assign errIrq    = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         brkTicks <= 8'h00;
      end else if (s.txSt != TX_BRK) begin
         brkTicks <= 8'h00;
      end else if (tick) begin
         brkTicks <= brkTicks + 8'h01;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   a_edge_flag_set: assert property (
      edgeEv |=> s.st2[B_RXEDGE]) else $error("edge flag not set");
   a_lin_blocks_rx: assert property (
      $rose(s.st1[B_RXFULL]) || $rose(s.st1[B_FRAMING]) |-> !$past(s.st2[B_LINDET]))
      else $error("full or framing set under lin detect");
   a_framing_full: assert property (
      $rose(s.st1[B_FRAMING]) |-> $rose(s.st1[B_RXFULL])) else $error("framing without full");
   a_break_thr: assert property (
      $rose(s.st2[B_LINBRK]) |-> $past(s.st2[B_LINDET]) && s.zRun == $past(thr))
      else $error("lin break at wrong run length");
   a_active_start: assert property (
      $rose(s.st2[B_RXACTIVE]) |-> $past(s.rxSt) == RX_START) else $error("active flag early");
   a_break_length: assert property (
      $fell(s.txSt == TX_BRK) |-> brkTicks == {s.txLen, 4'h0}) else $error("break length wrong");
   a_tx_idle_level: assert property (
      s.txSt == TX_IDLE |=> txPinOut == !$past(s.ct3[B_TXINVERT])) else $error("idle level wrong");
   a_single_wire_dir: assert property (
      swMode |=> txPinOe == $past(s.ct3[B_TXDIRECT])) else $error("tx direction wrong");
   a_overrun_irq: assert property (
      s.st1[B_OVERRUN] && s.ct3[B_OVRIE] |=> errIrq) else $error("overrun irq missing");
   a_noise_irq: assert property (
      s.st1[B_NOISE] && s.ct3[B_NOISEIE] |=> errIrq) else $error("noise irq missing");
   a_frame_irq: assert property (
      s.st1[B_FRAMING] && s.ct3[B_FRAMEIE] |=> errIrq) else $error("framing irq missing");
   a_parity_irq: assert property (
      s.st1[B_PARITY] && s.ct3[B_PARIE] |=> errIrq) else $error("parity irq missing");
   a_zero_write_keeps: assert property (
      s.dVal && s.dWr && s.dAdr == OFS_STAT2 && !hwdata[B_LINBRK] && s.st2[B_LINBRK]
      |=> s.st2[B_LINBRK]) else $error("zero write cleared flag");

endmodule

`default_nettype wire

// ---- ulc_pkg.sv ----
// ulc_pkg.sv: register map, field positions, frame counts and state types
// assumes a 32-bit AHB-Lite slave with one aligned word per register
`default_nettype none

package ulc_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [4:0] OFS_STAT2 = 5'h00;
   localparam logic [4:0] OFS_CTRL3 = 5'h04;
   localparam logic [4:0] OFS_DATA  = 5'h08;
   localparam logic [4:0] OFS_CTRL  = 5'h0C;
   localparam logic [4:0] OFS_STAT1 = 5'h10;
   localparam logic [4:0] OFS_BAUD  = 5'h14;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int B_LINBRK     = 7;
   localparam int B_RXEDGE     = 6;
   localparam int B_RXINVERT   = 4;
   localparam int B_IDLEWAKE   = 3;
   localparam int B_LONGBRK    = 2;
   localparam int B_LINDET     = 1;
   localparam int B_RXACTIVE   = 0;
   localparam int B_RXNINTH    = 7;
   localparam int B_TXNINTH    = 6;
   localparam int B_TXDIRECT   = 5;
   localparam int B_TXINVERT   = 4;
   localparam int B_OVRIE      = 3;
   localparam int B_NOISEIE    = 2;
   localparam int B_FRAMEIE    = 1;
   localparam int B_PARIE      = 0;
   localparam int B_NINEBIT    = 0;
   localparam int B_LOOPBACK   = 1;
   localparam int B_SINGLEWIRE = 2;
   localparam int B_RXENABLE   = 3;
   localparam int B_TXENABLE   = 4;
   localparam int B_SENDBRK    = 5;
   localparam int B_STANDBY    = 6;
   localparam int B_PARITYEN   = 7;
   localparam int B_RXFULL     = 5;
   localparam int B_IDLEFLAG   = 4;
   localparam int B_OVERRUN    = 3;
   localparam int B_NOISE      = 2;
   localparam int B_FRAMING    = 1;
   localparam int B_PARITY     = 0;

   // ----------------------------------------------------------------
   // sub-bit sampling and bit-time counts
   // ----------------------------------------------------------------
   localparam logic [3:0]  SUB_PRE     = 4'h7;
   localparam logic [3:0]  SUB_MID     = 4'h8;
   localparam logic [3:0]  SUB_POST    = 4'h9;
   localparam logic [3:0]  SUB_LAST    = 4'hF;
   localparam logic [3:0]  DATA8       = 4'h8;
   localparam logic [3:0]  DATA9       = 4'h9;
   localparam logic [3:0]  FRAME8      = 4'hA;
   localparam logic [3:0]  FRAME9      = 4'hB;
   localparam logic [3:0]  BRK_TX_STD  = 4'hA;
   localparam logic [3:0]  BRK_TX_LONG = 4'hD;
   localparam logic [3:0]  BRK_DET_STD = 4'hA;
   localparam logic [3:0]  BRK_DET_LIN = 4'hB;
   localparam logic [3:0]  NINE_ADD    = 4'h1;
   localparam logic [3:0]  RUN_MAX     = 4'hF;
   localparam logic [12:0] BAUD_RST    = 13'h0010;

   // ----------------------------------------------------------------
   // state types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00, RX_START = 2'b01, RX_DATA = 2'b10, RX_HOLD = 2'b11
   } ulc_rx_t;

   typedef enum logic [1:0] {
      TX_IDLE = 2'b00, TX_SHIFT = 2'b01, TX_BRK = 2'b10
   } ulc_tx_t;

   typedef struct packed {
      logic [7:0]  st2;
      logic [7:0]  ct3;
      logic [7:0]  ctl;
      logic [7:0]  st1;
      logic [12:0] baud;
      logic        armed;
      logic [7:0]  rxd;
      ulc_rx_t     rxSt;
      logic [3:0]  rxSub;
      logic [3:0]  rxBit;
      logic [8:0]  rxSh;
      logic        rxNz;
      logic        smp;
      logic        rxPrev;
      logic [3:0]  zRun;
      logic [3:0]  oRun;
      ulc_tx_t     txSt;
      logic [3:0]  txSub;
      logic [3:0]  txBit;
      logic [3:0]  txLen;
      logic [10:0] txSh;
      logic [8:0]  txBuf;
      logic        txFull;
      logic        dVal;
      logic        dWr;
      logic [4:0]  dAdr;
      logic [15:0] rdat;
      logic        rdy;
      logic        txPin;
      logic        txOe;
      logic        irq;
   } ulc_state_t;

   localparam ulc_state_t ST_RST = '{baud: BAUD_RST, rxPrev: 1'b1, rdy: 1'b1, txSt: TX_IDLE,
                                     txPin: 1'b1, txOe: 1'b1, rxSt: RX_IDLE, default: '0};

endpackage

`default_nettype wire

// ---- ulc_sync.sv ----
// ulc_sync.sv: three-stage pin synchroniser with agreement filter
// assumes the input is asynchronous to clk_sys
`default_nettype none

module ulc_sync #(
   parameter logic RST = 1'b1
) (
   input  wire logic clk_sys,
   input  wire logic nrst,
   input  wire logic d,
   output var  logic q
);

   logic [2:0] ff;

   // only the second and third stages are compared
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         ff <= {3{RST}};
         q  <= RST;
      end else begin
         ff <= {ff[1:0], d};
         if (ff[1] == ff[2]) begin
            q <= ff[2];
         end
      end
   end

endmodule

`default_nettype wire

// ---- ulc_baud.sv ----
// ulc_baud.sv: sub-bit enable divider, sixteen pulses per bit time
// assumes a divisor of zero stops the serial logic
`default_nettype none

module ulc_baud #(
   parameter int W = 13
) (
   input  wire logic         clk_sys,
   input  wire logic         nrst,
   input  wire logic [W-1:0] div,
   output var  logic         tick
);

   logic [W-1:0] cnt;

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (div == '0) begin
         cnt  <= '0;
         tick <= 1'b0;
      end else if (cnt + W'(1) >= div) begin
         cnt  <= '0;
         tick <= 1'b1;
      end else begin
         cnt  <= cnt + W'(1);
         tick <= 1'b0;
      end
   end

endmodule

`default_nettype wire

// ---- ulc_peer.sv ----
// ulc_peer.sv: behavioural serial node facing the line pins
// assumes one bit time is sixteen clk_sys cycles (baud divisor 1)
`default_nettype none

module ulc_peer (
   input  wire logic clk_sys,
   input  wire logic txLine,
   output var  logic rxLine
);
   timeunit 1ns;
   timeprecision 1ps;
   logic pol = 1'b0;
   initial rxLine = 1'b1;
   // -----------------------------------------------------------
   // line level between frames is the idle level, held low when polarity is inverted
   // -----------------------------------------------------------
   task automatic idle(input logic p);
      @(posedge clk_sys);
      pol = p;
      rxLine <= ~p;
   endtask
   task automatic send(input logic [10:0] b, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_sys);
         rxLine <= b[i] ^ pol;
         repeat (15) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      rxLine <= ~pol;
   endtask
   // samples mid-bit; a stuck line times out
   task automatic grab(output logic [10:0] b, input int n);
      b = '0;
      for (int t = 0; t < 3000 && txLine !== 1'b0; t++) @(posedge clk_sys);
      repeat (8) @(posedge clk_sys);
      for (int i = 0; i < n; i++) begin
         b[i] = txLine;
         repeat (16) @(posedge clk_sys);
      end
   endtask
endmodule

`default_nettype wire

// ---- tb.sv ----
// tb.sv: self-checking bench for the serial line status/control block
// assumes ulc_top as one AHB-Lite slave and ulc_peer on the line
`default_nettype none

module tb;
   import ulc_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0;
   logic        nrst = 1'b0;
   logic        hsel = 1'b0;
   logic [31:0] haddr = '0;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata, r, v;
   logic        hreadyout, hresp, rxPin, txPinIn, txPinOut, txPinOe, errIrq, nine, inv;
   logic [10:0] b;
   logic [31:0] seed = 32'h0000_0060;
   int          n_fail = 0;
   int          compares = 0;
   int          k;
   always #5 clk_sys = ~clk_sys;
   // single-wire pin pulled up when txPinOe is low
   assign txPinIn = txPinOe ? txPinOut : 1'b1;
   ulc_top u_dut (.clk_sys(clk_sys), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
      .rxPin(rxPin), .txPinIn(txPinIn), .txPinOut(txPinOut), .txPinOe(txPinOe),
      .errIrq(errIrq));
   ulc_peer u_peer (.clk_sys(clk_sys), .txLine(txPinOut), .rxLine(rxPin));
   // -----------------------------------------------------------
   // helpers
   // -----------------------------------------------------------
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [10:0] frm(input logic [8:0] d, input logic n9, input logic stp);
      return n9 ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
   endfunction
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         n_fail++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic xfer(input logic [4:0] a, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      haddr <= {27'h000_0000, a};
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h00_0000, d};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_sys);
      n_fail++;
      conclude();
   end
   // -----------------------------------------------------------
   // scenarios
   // -----------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk_sys);
      nrst <= 1'b1;
      xfer(OFS_STAT2, 1'b0, 8'h00);
      chk(r, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         v = rnd();
         xfer(OFS_CTRL3, 1'b1, v[7:0]);
         xfer(OFS_CTRL3, 1'b0, 8'h00);
         chk(r, {24'h00_0000, v[7:0] & 8'h7F});
         xfer(OFS_STAT2, 1'b1, (v[7:0] & 8'h0E) | 8'hC1);
         xfer(OFS_STAT2, 1'b0, 8'h00);
         chk(r, {24'h00_0000, v[7:0] & 8'h0E});
      end
      xfer(OFS_BAUD, 1'b1, 8'h01);
      xfer(OFS_CTRL3, 1'b1, 8'h00);
      for (int i = 0; i < 4; i++) begin
         nine = i[0];
         inv = i[1];
         v = rnd();
         u_peer.idle(inv);
         xfer(OFS_CTRL, 1'b1, {7'h0C, nine});
         xfer(OFS_STAT2, 1'b1, {3'b110, inv, 4'h0});
         repeat (300) @(posedge clk_sys);
         xfer(OFS_STAT2, 1'b1, {3'b110, inv, 4'h0});
         xfer(OFS_STAT1, 1'b0, 8'h00);
         xfer(OFS_DATA, 1'b0, 8'h00);
         fork
            u_peer.send(frm(v[8:0], nine, 1'b1), 10 + nine);
            begin
               repeat (60) @(posedge clk_sys);
               xfer(OFS_STAT2, 1'b0, 8'h00);
               chk(r[0], 1'b1);
            end
         join
         repeat (8) @(posedge clk_sys);
         xfer(OFS_CTRL3, 1'b0, 8'h00);
         if (nine) chk(r[7], v[8]);
         xfer(OFS_STAT2, 1'b0, 8'h00);
         chk(r[7:6], 2'b01);
         xfer(OFS_STAT1, 1'b0, 8'h00);
         chk(r[5:0], 6'h20);
         xfer(OFS_DATA, 1'b0, 8'h00);
         chk(r[7:0], v[7:0]);
         repeat (200) @(posedge clk_sys);
         xfer(OFS_STAT2, 1'b0, 8'h00);
         chk(r[0], 1'b0);
      end
      u_peer.idle(1'b0);
      xfer(OFS_STAT2, 1'b1, 8'hC4);
      xfer(OFS_CTRL, 1'b1, 8'h18);
      xfer(OFS_CTRL3, 1'b1, 8'h0A);
      repeat (300) @(posedge clk_sys);
      xfer(OFS_STAT1, 1'b0, 8'h00);
      xfer(OFS_DATA, 1'b0, 8'h00);
      u_peer.send(frm(9'h055, 1'b0, 1'b0), 10);
      repeat (8) @(posedge clk_sys);
      xfer(OFS_STAT1, 1'b0, 8'h00);
      chk(r[5:0] & 6'h22, 6'h22);
      chk(errIrq, 1'b1);
      xfer(OFS_DATA, 1'b0, 8'h00);
      @(posedge clk_sys);
      chk(errIrq, 1'b0);
      u_peer.send(frm(9'h0A5, 1'b0, 1'b1), 10);
      u_peer.send(frm(9'h05A, 1'b0, 1'b1), 10);
      repeat (8) @(posedge clk_sys);
      chk(errIrq, 1'b1);
      xfer(OFS_STAT1, 1'b0, 8'h00);
      chk(r[3], 1'b1);
      xfer(OFS_DATA, 1'b0, 8'h00);
      xfer(OFS_STAT2, 1'b1, 8'hC2);
      u_peer.send(frm(9'h055, 1'b0, 1'b0), 10);
      repeat (8) @(posedge clk_sys);
      xfer(OFS_STAT1, 1'b0, 8'h00);
      chk(r[5:0] & 6'h22, 6'h00);
      u_peer.send(11'h000, 10);
      repeat (200) @(posedge clk_sys);
      xfer(OFS_STAT2, 1'b0, 8'h00);
      chk(r[7], 1'b0);
      u_peer.send(11'h000, 11);
      repeat (200) @(posedge clk_sys);
      xfer(OFS_STAT2, 1'b0, 8'h00);
      chk(r[7], 1'b1);
      xfer(OFS_STAT2, 1'b1, 8'hC2);
      xfer(OFS_STAT2, 1'b0, 8'h00);
      chk(r[7:0], 8'h02);
      xfer(OFS_BAUD, 1'b1, 8'h08);
      for (int i = 0; i < 4; i++) begin
         nine = i[1];
         inv = i[0] ^ i[1];
         xfer(OFS_CTRL, 1'b1, {7'h0C, nine});
         xfer(OFS_CTRL3, 1'b1, {3'b000, inv, 4'h0});
         xfer(OFS_STAT2, 1'b1, {5'h00, i[0], 2'b00});
         repeat (300) @(posedge clk_sys);
         k = 0;
         fork
            begin
               for (int t = 0; t < 4000 && txPinOut !== inv; t++) @(posedge clk_sys);
               while (txPinOut === inv && k < 4000) begin
                  k++;
                  @(posedge clk_sys);
               end
            end
            begin
               xfer(OFS_CTRL, 1'b1, {7'h1C, nine});
               while (txPinOut !== inv) @(posedge clk_sys);
               xfer(OFS_CTRL, 1'b1, {7'h0C, nine});
            end
         join
         chk(k, ((i[0] ? 13 : 10) + nine) * 128);
      end
      xfer(OFS_BAUD, 1'b1, 8'h01);
      xfer(OFS_CTRL, 1'b1, 8'h19);
      xfer(OFS_CTRL3, 1'b1, 8'h40);
      for (int i = 0; i < 2; i++) begin
         v = rnd();
         fork
            u_peer.grab(b, 11);
            xfer(OFS_DATA, 1'b1, v[7:0]);
         join
         chk(b, frm({1'b1, v[7:0]}, 1'b1, 1'b1));
      end
      xfer(OFS_CTRL, 1'b1, 8'h06);
      xfer(OFS_CTRL3, 1'b1, 8'h00);
      repeat (2) @(posedge clk_sys);
      chk(txPinOe, 1'b0);
      xfer(OFS_CTRL3, 1'b1, 8'h20);
      repeat (2) @(posedge clk_sys);
      chk(txPinOe, 1'b1);
      conclude();
   end
endmodule

`default_nettype wire
